// file: seq_reset_pkg.sv
package seq_reset_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam logic [9:0]  BLINK_LAST_MS = 10'(BLINK_HALF_MS - 1);

    // button layout: low half enclosure side, high half outer side
    localparam int unsigned MAX_SIDE  = 8;
    localparam int unsigned BTN_COUNT = 2 * MAX_SIDE;
    localparam int unsigned MS_W      = 16;

    // register map
    localparam int unsigned AXI_AW      = 8;
    localparam logic [7:0]  ADDR_CFG     = 8'h00;
    localparam logic [7:0]  ADDR_MINPUSH = 8'h04;
    localparam logic [7:0]  ADDR_MAXGAP  = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0c;

    // field positions
    localparam int unsigned CFG_IN_LSB    = 0;
    localparam int unsigned CFG_OUT_LSB   = 8;
    localparam int unsigned STAT_CONF_BIT = 0;
    localparam int unsigned STAT_LOCK_BIT = 1;
    localparam int unsigned STAT_ST_LSB   = 2;
    localparam int unsigned STAT_POS_LSB  = 8;

    // reset values
    localparam logic [3:0]      RST_INSIDE  = 4'h0;
    localparam logic [3:0]      RST_OUTSIDE = 4'h1;
    localparam logic [MS_W-1:0] RST_MINPUSH = 16'h0064;
    localparam logic [MS_W-1:0] RST_MAXGAP  = 16'h2710;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_INSIDE  = 2'h0,
        ST_OUTSIDE = 2'h1,
        ST_DONE    = 2'h3
    } seqState_t;

    typedef struct packed {
        logic [AXI_AW-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [AXI_AW-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } axiLiteReq_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axiLiteRsp_t;

endpackage

// file: press_filter.sv
module press_filter #(
    parameter int unsigned MS_W = seq_reset_pkg::MS_W
) (
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  wire logic            buttonPin,
    input  wire logic            msTick,
    input  wire logic            clear,
    input  wire logic [MS_W-1:0] minPush,
    output      logic            pressValid
);

    logic            syncA;
    logic            syncB;
    logic            held;
    logic [MS_W-1:0] highMs;

    // a press ends on the falling edge after the high stretch
    wire fallEdge   = held & ~syncB;
    wire longEnough = highMs >= minPush;
    wire atMax      = &highMs;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            syncA      <= 1'b0;
            syncB      <= 1'b0;
            held       <= 1'b0;
            pressValid <= 1'b0;
            highMs     <= '0;
        end
        else
        begin
            syncA      <= buttonPin;
            syncB      <= syncA;
            held       <= syncB;
            pressValid <= fallEdge & longEnough & ~clear;
            // saturate so a stuck button cannot wrap into a short press
            if (clear || !syncB)
                highMs <= '0;
            else if (msTick && !atMax)
                highMs <= highMs + 1'b1;
        end
    end

    property p_min_push;
        @(posedge clk_sys) disable iff (rst)
        pressValid |-> $past(highMs) >= $past(minPush);
    endproperty
    a_min_push: assert property (p_min_push)
        else $error("press accepted shorter than minimum");

    sequence s_high_then_low;
        $past(held) && !$past(syncB);
    endsequence

    property p_press_shape;
        @(posedge clk_sys) disable iff (rst)
        pressValid |-> s_high_then_low;
    endproperty
    a_press_shape: assert property (p_press_shape)
        else $error("press accepted without a falling edge");

endmodule

// file: multi_button_reset_sequencer.sv
// Notes on behaviour
// - guard low is ignored while enclosure buttons are still being collected
// - after the first outer press is accepted the guard must stay high
// - guard low in that phase drops all progress and restarts from step one
// - confirmed rises once every configured press was taken in order
// - guard falling outside the enclosure phase forces confirmed low
// - lamp of the next button blinks 500 ms high, 500 ms low; others dark
// - gap between accepted presses above the maximum restarts the sequence
// - a press counts only if held high for at least the minimum time
// - enclosure button count is 0 to 8; zero means outer buttons only
// - outer button count is 1 to 8, never fewer than one
// - completion only ever happens on an outer button press
// - a press is a low-high-low pulse on the button input
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module multi_button_reset_sequencer #(
    parameter int unsigned MS_CYCLES = seq_reset_pkg::MS_CYCLES
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire seq_reset_pkg::axiLiteReq_t axiReq,
    output      seq_reset_pkg::axiLiteRsp_t axiRsp,
    input  wire logic                       guardPin,
    input  wire logic [15:0]                buttonPin,
    output      logic                       confirmed,
    output      logic [15:0]                lamp
);

    localparam int unsigned BTN   = seq_reset_pkg::BTN_COUNT;
    localparam int unsigned MSW   = seq_reset_pkg::MS_W;
    localparam int unsigned DIV_W = $clog2(MS_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
    localparam logic [3:0] SIDE4 = 4'(seq_reset_pkg::MAX_SIDE);
    localparam logic [3:0] ONE4  = 4'h1;

    // ---- register file state ----
    logic [3:0]     nIn;
    logic [3:0]     nOut;
    logic [MSW-1:0] minPush;
    logic [MSW-1:0] maxGap;

    // ---- bus slave state ----
    logic        awHeld;
    logic [7:0]  awAddrQ;
    logic        wHeld;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;

    // ---- sequencer state ----
    seq_reset_pkg::seqState_t state;
    seq_reset_pkg::seqState_t next_state;
    logic [4:0]       pos;
    logic [DIV_W-1:0] msDiv;
    logic             msTick;
    logic [MSW-1:0]   gapMs;
    logic [9:0]       blinkMs;
    logic             blinkPhase;
    logic             guardA;
    logic             guardB;
    logic [BTN-1:0]   pressValid;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[8*b +: 8] = data[8*b +: 8];
        return res;
    endfunction

    // ---- AXI4-Lite decode ----
    wire [7:0] wrAddr  = {awAddrQ[7:2], 2'h0};
    wire [7:0] rdAddr  = {axiReq.araddr[7:2], 2'h0};
    wire       wrCfg   = wrAddr == seq_reset_pkg::ADDR_CFG;
    wire       wrMin   = wrAddr == seq_reset_pkg::ADDR_MINPUSH;
    wire       wrGap   = wrAddr == seq_reset_pkg::ADDR_MAXGAP;
    wire       wrStat  = wrAddr == seq_reset_pkg::ADDR_STATUS;
    wire       wrHit   = wrCfg | wrMin | wrGap | wrStat;
    wire       awTake  = axiReq.awvalid & ~awHeld & ~bValid;
    wire       wTake   = axiReq.wvalid & ~wHeld & ~bValid;
    wire       doWrite = awHeld & wHeld & ~bValid;
    wire       arTake  = axiReq.arvalid & ~rValid;
    // any settings change restarts so no half-done sequence mixes two setups
    wire       cfgWr   = doWrite & (wrCfg | wrMin | wrGap);

    wire [31:0] cfgWord = (32'(nIn) << seq_reset_pkg::CFG_IN_LSB)
                        | (32'(nOut) << seq_reset_pkg::CFG_OUT_LSB);
    wire [31:0] cfgNew  = merge(cfgWord, wDataQ, wStrbQ);
    wire [31:0] minNew  = merge(32'(minPush), wDataQ, wStrbQ);
    wire [31:0] gapNew  = merge(32'(maxGap), wDataQ, wStrbQ);
    wire [3:0]  inRaw   = cfgNew[seq_reset_pkg::CFG_IN_LSB +: 4];
    wire [3:0]  outRaw  = cfgNew[seq_reset_pkg::CFG_OUT_LSB +: 4];
    wire [3:0]  inClamp = (inRaw > SIDE4) ? SIDE4 : inRaw;
    wire [3:0]  outClamp = (outRaw == 4'h0) ? ONE4
                         : (outRaw > SIDE4) ? SIDE4 : outRaw;

    // ---- sequence position and expectation ----
    wire [4:0]  total     = {1'b0, nIn} + {1'b0, nOut};
    wire [4:0]  posInc    = pos + 5'h01;
    wire        posInside = pos < {1'b0, nIn};
    wire [4:0]  outerOff  = pos - {1'b0, nIn};
    wire [3:0]  expIdx    = posInside ? pos[3:0]
                                      : SIDE4 + outerOff[3:0];
    wire [BTN-1:0] expMask = BTN'(1) << expIdx;
    wire        gd        = guardB;

    // a press is taken only while the state agrees with the position
    wire phaseOk = (state == seq_reset_pkg::ST_INSIDE && posInside)
                 || state == seq_reset_pkg::ST_OUTSIDE;
    wire rightPress = phaseOk & pressValid[expIdx];
    wire stray = (state != seq_reset_pkg::ST_DONE)
               & (|(pressValid & ~expMask));
    wire lastStep = rightPress & (posInc == total);
    // guard only counts once an outer press has gone through
    wire outerLocked = (state == seq_reset_pkg::ST_OUTSIDE
                        && pos > {1'b0, nIn})
                     || state == seq_reset_pkg::ST_DONE;
    wire guardAbort = outerLocked & ~gd;
    wire gapExpired = (pos != 5'h00)
                    & (state != seq_reset_pkg::ST_DONE)
                    & (gapMs > maxGap);
    // completing with the guard already low would give a one-cycle blip
    wire finalLow   = lastStep & ~gd;
    wire restart    = guardAbort | gapExpired | stray | cfgWr | finalLow;

    always_comb
    begin
        next_state = state;
        unique case (state)
            seq_reset_pkg::ST_INSIDE:
                if (!posInside || (rightPress && posInc == {1'b0, nIn}))
                    next_state = seq_reset_pkg::ST_OUTSIDE;
            seq_reset_pkg::ST_OUTSIDE:
                if (lastStep)
                    next_state = seq_reset_pkg::ST_DONE;
            seq_reset_pkg::ST_DONE:
                next_state = seq_reset_pkg::ST_DONE;
            default:
                next_state = seq_reset_pkg::ST_INSIDE;
        endcase
    end

    // ---- per-button press filters ----
    genvar gi;
    generate
        for (gi = 0; gi < BTN; gi++)
        begin : g_btn
            press_filter #(
                .MS_W (MSW)
            ) u_press (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .buttonPin  (buttonPin[gi]),
                .msTick     (msTick),
                .clear      (restart),
                .minPush    (minPush),
                .pressValid (pressValid[gi])
            );
        end
    endgenerate

    // ---- bus slave ----
    wire [31:0] statWord =
          (32'(confirmed) << seq_reset_pkg::STAT_CONF_BIT)
        | (32'(outerLocked) << seq_reset_pkg::STAT_LOCK_BIT)
        | (32'(state) << seq_reset_pkg::STAT_ST_LSB)
        | (32'(pos) << seq_reset_pkg::STAT_POS_LSB);
    wire rdCfg  = rdAddr == seq_reset_pkg::ADDR_CFG;
    wire rdMin  = rdAddr == seq_reset_pkg::ADDR_MINPUSH;
    wire rdGap  = rdAddr == seq_reset_pkg::ADDR_MAXGAP;
    wire rdStat = rdAddr == seq_reset_pkg::ADDR_STATUS;
    wire rdHit  = rdCfg | rdMin | rdGap | rdStat;
    wire [31:0] rdMux = rdCfg  ? cfgWord
                      : rdMin  ? 32'(minPush)
                      : rdGap  ? 32'(maxGap)
                      : rdStat ? statWord : 32'h0000_0000;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            awHeld  <= 1'b0;
            awAddrQ <= 8'h00;
            wHeld   <= 1'b0;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
            bValid  <= 1'b0;
            bResp   <= seq_reset_pkg::RESP_OKAY;
        end
        else
        begin
            if (awTake)
            begin
                awHeld  <= 1'b1;
                awAddrQ <= axiReq.awaddr;
            end
            if (wTake)
            begin
                wHeld  <= 1'b1;
                wDataQ <= axiReq.wdata;
                wStrbQ <= axiReq.wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
                bValid <= 1'b1;
                bResp  <= wrHit ? seq_reset_pkg::RESP_OKAY
                                : seq_reset_pkg::RESP_SLVERR;
            end
            else if (bValid && axiReq.bready)
                bValid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rValid <= 1'b0;
            rData  <= 32'h0000_0000;
            rResp  <= seq_reset_pkg::RESP_OKAY;
        end
        else if (arTake)
        begin
            rValid <= 1'b1;
            rData  <= rdMux;
            rResp  <= rdHit ? seq_reset_pkg::RESP_OKAY
                            : seq_reset_pkg::RESP_SLVERR;
        end
        else if (rValid && axiReq.rready)
            rValid <= 1'b0;
    end

    // status is read only; writes to it are answered but change nothing
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            nIn     <= seq_reset_pkg::RST_INSIDE;
            nOut    <= seq_reset_pkg::RST_OUTSIDE;
            minPush <= seq_reset_pkg::RST_MINPUSH;
            maxGap  <= seq_reset_pkg::RST_MAXGAP;
        end
        else if (doWrite)
        begin
            if (wrCfg)
            begin
                nIn  <= inClamp;
                nOut <= outClamp;
            end
            if (wrMin)
                minPush <= minNew[MSW-1:0];
            if (wrGap)
                maxGap <= gapNew[MSW-1:0];
        end
    end

    assign axiRsp = '{awready: ~awHeld & ~bValid,
                      wready:  ~wHeld & ~bValid,
                      bvalid:  bValid,
                      bresp:   bResp,
                      arready: ~rValid,
                      rvalid:  rValid,
                      rdata:   rData,
                      rresp:   rResp};

    // ---- time base and guard synchroniser ----
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            msDiv  <= '0;
            msTick <= 1'b0;
            guardA <= 1'b0;
            guardB <= 1'b0;
        end
        else
        begin
            msTick <= msDiv == DIV_LAST;
            msDiv  <= (msDiv == DIV_LAST) ? '0 : msDiv + 1'b1;
            guardA <= guardPin;
            guardB <= guardA;
        end
    end

    // ---- sequencer ----
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state     <= seq_reset_pkg::ST_INSIDE;
            pos       <= 5'h00;
            confirmed <= 1'b0;
        end
        else if (restart)
        begin
            state     <= seq_reset_pkg::ST_INSIDE;
            pos       <= 5'h00;
            confirmed <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            pos       <= rightPress ? posInc : pos;
            confirmed <= next_state == seq_reset_pkg::ST_DONE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            gapMs <= '0;
        else if (restart || rightPress)
            gapMs <= '0;
        else if (msTick && !(&gapMs))
            gapMs <= gapMs + 1'b1;
    end

    // blink runs freely so every lamp shares one phase
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            blinkMs    <= 10'h000;
            blinkPhase <= 1'b0;
            lamp       <= '0;
        end
        else
        begin
            if (msTick)
            begin
                blinkMs <= (blinkMs == seq_reset_pkg::BLINK_LAST_MS)
                         ? 10'h000 : blinkMs + 10'h001;
                if (blinkMs == seq_reset_pkg::BLINK_LAST_MS)
                    blinkPhase <= ~blinkPhase;
            end
            // dark for the step cycle so the old button never shows
            // alongside the new position or the confirmed output
            lamp <= (blinkPhase && phaseOk && !rightPress && !restart)
                  ? expMask : '0;
        end
    end

    // ---- checks ----
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_inside_tolerant;
        (state == seq_reset_pkg::ST_INSIDE && !gd && !gapExpired
         && !stray && !cfgWr) |=> pos >= $past(pos);
    endproperty
    a_inside_tolerant: assert property (p_inside_tolerant)
        else $error("guard low aborted the enclosure phase");

    property p_guard_abort;
        (outerLocked && !gd) |=>
            (pos == 5'h00 && state == seq_reset_pkg::ST_INSIDE);
    endproperty
    a_guard_abort: assert property (p_guard_abort)
        else $error("guard drop did not restart the sequence");

    sequence s_final_press;
        state == seq_reset_pkg::ST_OUTSIDE && lastStep && gd
        && !stray && !gapExpired && !cfgWr;
    endsequence

    property p_complete;
        s_final_press |=> confirmed ##1 (confirmed || $past(restart));
    endproperty
    a_complete: assert property (p_complete)
        else $error("completed sequence did not confirm");

    property p_guard_drop_clears;
        (confirmed && !gd) |=> !confirmed;
    endproperty
    a_guard_drop_clears: assert property (p_guard_drop_clears)
        else $error("confirmed stayed high after guard dropped");

    property p_lamp_single;
        lamp != '0 |-> $onehot(lamp) && !confirmed;
    endproperty
    a_lamp_single: assert property (p_lamp_single)
        else $error("more than one lamp lit or lamp lit when done");

    property p_blink_period;
        (msTick && blinkMs == seq_reset_pkg::BLINK_LAST_MS)
            |=> blinkPhase != $past(blinkPhase);
    endproperty
    a_blink_period: assert property (p_blink_period)
        else $error("blink phase did not toggle after 500 ms");

    property p_gap_restart;
        gapExpired |=> pos == 5'h00;
    endproperty
    a_gap_restart: assert property (p_gap_restart)
        else $error("gap overrun did not restart");

    property p_cfg_range;
        nIn <= SIDE4 && nOut >= ONE4 && nOut <= SIDE4;
    endproperty
    a_cfg_range: assert property (p_cfg_range)
        else $error("button counts out of range");

    property p_done_from_outer;
        $rose(confirmed) |-> $past(state) == seq_reset_pkg::ST_OUTSIDE;
    endproperty
    a_done_from_outer: assert property (p_done_from_outer)
        else $error("completion not reached on an outer press");

    property p_stray_restart;
        stray |=> pos == 5'h00 && !confirmed;
    endproperty
    a_stray_restart: assert property (p_stray_restart)
        else $error("wrong button did not restart");

    property p_restart_clears;
        restart |=> gapMs == '0;
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("gap counter not cleared on restart");

endmodule

// file: operator_panel.sv
module operator_panel
(
    input  wire logic [15:0] lamp,
    input  wire logic        clk_sys,
    output      logic [15:0] buttonPin,
    output      logic        guardPin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        buttonPin = 16'h0000;
        guardPin  = 1'b1;
    end

    // released contacts read low, so a press is always low-high-low
    task automatic press(input int idx, input int hold);
        buttonPin[idx] <= 1'b1;
        repeat (hold) @(posedge clk_sys);
        buttonPin[idx] <= 1'b0;
        // sync flops plus filter need a few cycles before the step lands
        repeat (12) @(posedge clk_sys);
    endtask

    task automatic guard(input logic v, input int hold);
        guardPin <= v;
        repeat (hold) @(posedge clk_sys);
    endtask

    task automatic countLit(input int idx, input int n, output int on,
                            output logic stray);
        logic [15:0] others;
        on = 0;
        stray = 1'b0;
        repeat (n)
        begin
            @(posedge clk_sys);
            others = lamp;
            others[idx] = 1'b0;
            if (lamp[idx] === 1'b1)
                on++;
            if (others !== 16'h0000)
                stray = 1'b1;
        end
    endtask
endmodule

// file: multi_button_reset_sequencer_bench.sv
module multi_button_reset_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned MSC = 10;

    logic                       clk_sys = 1'b0;
    logic                       rst = 1'b1;
    seq_reset_pkg::axiLiteReq_t req = '0;
    seq_reset_pkg::axiLiteRsp_t rsp;
    logic [15:0]                buttonPin;
    logic [15:0]                lamp;
    logic                       guardPin;
    logic                       confirmed;
    int                         failures = 0;
    int                         compares = 0;
    int                         cyc = 0;

    always #10 clk_sys = ~clk_sys;

    multi_button_reset_sequencer #(
        .MS_CYCLES (MSC)
    ) i_dut (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .axiReq    (req),
        .axiRsp    (rsp),
        .guardPin  (guardPin),
        .buttonPin (buttonPin),
        .confirmed (confirmed),
        .lamp      (lamp)
    );

    operator_panel i_op (
        .lamp      (lamp),
        .clk_sys   (clk_sys),
        .buttonPin (buttonPin),
        .guardPin  (guardPin)
    );

    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            failures++;
            close_out();
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // each task ends one edge after release so the next one never
    // assigns the same strobe twice in one time step
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (rsp.awready === 1'b1)
                req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1)
                req.wvalid <= 1'b0;
        end
        while (rsp.bvalid !== 1'b1);
        chk("bresp", (a < 8'h10) ? 32'h0 : 32'h2, 32'(rsp.bresp));
        req.bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdChk(input string n, input logic [7:0] a,
                         input logic [31:0] e, input logic [31:0] m);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (rsp.arready === 1'b1)
                req.arvalid <= 1'b0;
        end
        while (rsp.rvalid !== 1'b1);
        if (a == 8'h10)
            chk(n, e, 32'(rsp.rresp));
        else
            chk(n, e, rsp.rdata & m);
        req.rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic posChk(input logic [4:0] e);
        rdChk("position", 8'h0c, 32'(e) << 8, 32'h00001f00);
    endtask

    task automatic t_regs();
        rdChk("cfg reset", 8'h00, 32'h00000100, '1);
        rdChk("minpush reset", 8'h04, 32'h00000064, '1);
        rdChk("maxgap reset", 8'h08, 32'h00002710, '1);
        rdChk("unmapped resp", 8'h10, 32'h00000002, '1);
        axw(8'h10, 32'h00000005);
        axw(8'h00, 32'h00000009);
        rdChk("cfg clamp", 8'h00, 32'h00000108, '1);
        axw(8'h04, 32'h00000002);
        axw(8'h08, 32'h00000014);
        axw(8'h00, 32'h00000202);
        $display("t_regs ended");
    endtask

    task automatic t_blink();
        int   on;
        logic stray;
        i_op.countLit(0, 1000 * MSC, on, stray);
        chk("lamp on time", 32'(500 * MSC), 32'(on));
        chk("other lamps", 32'h0, 32'(stray));
        $display("t_blink ended");
    endtask

    task automatic t_seq();
        i_op.press(0, 40);
        i_op.guard(1'b0, 50);
        i_op.guard(1'b1, 5);
        i_op.press(1, 40);
        i_op.press(8, 40);
        chk("early confirm", 32'h0, 32'(confirmed));
        i_op.press(9, 40);
        chk("confirmed", 32'h1, 32'(confirmed));
        rdChk("status done", 8'h0c, 32'h0000040f, '1);
        i_op.guard(1'b0, 10);
        chk("guard drop", 32'h0, 32'(confirmed));
        i_op.guard(1'b1, 5);
        i_op.press(9, 40);
        chk("no resume", 32'h0, 32'(confirmed));
        $display("t_seq ended");
    endtask

    task automatic t_abort();
        i_op.press(0, 40);
        i_op.press(1, 40);
        i_op.press(8, 40);
        i_op.guard(1'b0, 10);
        i_op.guard(1'b1, 5);
        posChk(5'h00);
        i_op.press(9, 40);
        chk("after abort", 32'h0, 32'(confirmed));
        $display("t_abort ended");
    endtask

    task automatic t_order();
        i_op.press(0, 40);
        posChk(5'h01);
        i_op.press(8, 40);
        posChk(5'h00);
        i_op.press(0, 5);
        posChk(5'h00);
        i_op.press(0, 40);
        posChk(5'h01);
        repeat (30 * MSC) @(posedge clk_sys);
        posChk(5'h00);
        $display("t_order ended");
    endtask

    task automatic t_outonly();
        axw(8'h00, 32'h00000100);
        i_op.press(8, 40);
        chk("outer only", 32'h1, 32'(confirmed));
        $display("t_outonly ended");
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_blink();
        t_seq();
        t_abort();
        t_order();
        t_outonly();
        close_out();
    end
endmodule
